// *** hdl/sdmc_top.sv ***
// special drive mode controller with AHB-Lite register slave
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
module sdmc_top
	import sdmc_pkg::*;
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// digital inputs 1..6 and analog sample
	input wire logic [5:0] DIN,
	input wire logic [11:0] ADC_DATA,
	input wire logic ADC_VALID,
	// motion outputs
	output logic STEP,
	output logic STEP_DIR,
	output logic CLOSED_LOOP,
	output sdmc_op_e OP_MODE,
	output logic MOTION_EN,
	output logic [31:0] TARGET_VEL
);
	// configuration: mode staged by software, saved, and live after restart; scale and wiring take effect at once
	sdmc_cfg_s staged_ff, saved_ff, active_ff;
	logic [15:0] num_ff, den_ff;
	logic diff_ff;

	// bus pipeline
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic [31:0] rdata_ff;
	logic ready_ff;

	// pin levels and outputs
	logic en_q, dir_q, clk_q, clk_prev_ff;
	logic step_ff, step_dir_ff, closed_ff, men_ff;
	sdmc_op_e op_ff;
	logic [31:0] target_ff;

	// velocity engine
	typedef enum logic {V_IDLE, V_DIV} sdmc_vst_e;
	sdmc_vst_e vst_ff;
	logic neg_ff;
	logic div_done;
	logic [47:0] div_quo;

	// address phase decode; only word transfers are defined
	wire addr_ok = HSEL & HTRANS[1] & HREADY;
	wire rd_req = addr_ok & ~HWRITE;
	wire wr_req = addr_ok & HWRITE;
	wire [7:0] raddr = {HADDR[7:2], 2'b00};

	// data phase write strobes
	wire wr_app = wr_pend_ff & (wr_addr_ff == OFS_APP_CAT);
	wire wr_mode = wr_pend_ff & (wr_addr_ff == OFS_MODE);
	wire wr_store = wr_pend_ff & (wr_addr_ff == OFS_STORE);
	wire wr_restart = wr_pend_ff & (wr_addr_ff == OFS_RESTART);
	wire wr_num = wr_pend_ff & (wr_addr_ff == OFS_SCALE_NUM);
	wire wr_den = wr_pend_ff & (wr_addr_ff == OFS_SCALE_DEN);
	wire wr_diff = wr_pend_ff & (wr_addr_ff == OFS_DIFF);
	wire sig_ok = (HWDATA == SAVE_SIG);

	// live mode decode
	wire special = (active_ff.app_cat == ACT_SPECIAL);
	wire sdmc_dec_s dec = sdmc_decode(active_ff.mode);
	wire sdmc_op_e op = special ? dec.op : OP_FIELDBUS;
	wire sdmc_dec_s stg_dec = sdmc_decode(staged_ff.mode);

	// status word: live state, staged operating mode and pin levels
	wire [31:0] status = {16'h0000, stg_dec.op, special, en_q, dir_q,
		clk_q, men_ff, 2'b00, closed_ff, op_ff, active_ff.mode};

	// read mux; unmapped offsets read zero
	logic [31:0] rmux;
	always_comb
	begin
		unique case (raddr)
			OFS_APP_CAT: rmux = {24'h000000, staged_ff.app_cat};
			OFS_MODE: rmux = {28'h0000000, staged_ff.mode};
			OFS_SCALE_NUM: rmux = {16'h0000, num_ff};
			OFS_SCALE_DEN: rmux = {16'h0000, den_ff};
			OFS_DIFF: rmux = {31'h00000000, diff_ff};
			OFS_STATUS: rmux = status;
			OFS_TARGET: rmux = target_ff;
			default: rmux = 32'h00000000;
		endcase
	end

	// bus pipeline: zero wait states, always OKAY
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			rdata_ff <= 32'h00000000;
			ready_ff <= 1'b1;
		end
		else
		begin
			wr_pend_ff <= wr_req;
			wr_addr_ff <= wr_req ? raddr : wr_addr_ff;
			rdata_ff <= rd_req ? rmux : rdata_ff;
			ready_ff <= 1'b1;
		end
	end

	// staged fields take software writes directly
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			staged_ff <= '{app_cat: RST_APP_CAT, mode: RST_MODE};
			num_ff <= RST_SCALE;
			den_ff <= RST_SCALE;
			diff_ff <= 1'b0;
		end
		else
		begin
			if (wr_app)
				staged_ff.app_cat <= HWDATA[7:0];
			if (wr_mode)
				staged_ff.mode <= HWDATA[3:0];
			if (wr_num)
				num_ff <= HWDATA[15:0];
			if (wr_den)
				den_ff <= HWDATA[15:0];
			if (wr_diff)
				diff_ff <= HWDATA[0];
		end
	end

	// the live mode only changes on a restart, so a half-written
	// configuration can never reach the motor
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			saved_ff <= '{app_cat: RST_APP_CAT, mode: RST_MODE};
			active_ff <= '{app_cat: RST_APP_CAT, mode: RST_MODE};
		end
		else
		begin
			if (wr_store && sig_ok)
				saved_ff <= staged_ff;
			if (wr_restart)
				active_ff <= saved_ff;
		end
	end

	// input mapping, single-ended or differential
	sdmc_in_map u_map (
		.din(DIN),
		.diff(diff_ff),
		.en(en_q),
		.dir(dir_q),
		.clk(clk_q)
	);

	// step on each enabled rising clock edge in clock-direction mode
	wire stepping = (op == OP_CLKDIR);
	wire step_nxt = stepping & en_q & clk_q & ~clk_prev_ff;

	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			clk_prev_ff <= 1'b0;
			step_ff <= 1'b0;
			step_dir_ff <= 1'b0;
		end
		else
		begin
			clk_prev_ff <= clk_q;
			step_ff <= step_nxt;
			step_dir_ff <= step_nxt ? dir_q : step_dir_ff;
		end
	end

	// analog magnitude and sense; joystick is centred on half scale
	wire [12:0] joy_diff = {1'b0, ADC_DATA} - {1'b0, ADC_HALF};
	wire joy_neg = joy_diff[12];
	wire [11:0] joy_mag = joy_neg ? 12'(ADC_HALF - ADC_DATA) : joy_diff[11:0];
	wire [11:0] mag = dec.joystick ? joy_mag : ADC_DATA;
	wire neg_nxt = dec.joystick ? joy_neg : ~dir_q;
	wire dead = (mag <= DEAD_CNT);
	wire [11:0] span = dec.joystick ? ADC_HALF : ADC_FULL;
	wire [9:0] vmax = dec.slow ? RPM_SLOW : RPM_FAST;
	wire [15:0] den_eff = (den_ff == 16'h0000) ? RST_SCALE : den_ff;

	// speed = mag * vmax * num / (span * den)
	wire [47:0] dividend = 48'(mag) * 48'(vmax) * 48'(num_ff);
	wire [31:0] divisor = 32'(span) * 32'(den_eff);
	wire analog = (op == OP_VELOCITY);
	wire take_sample = analog & ADC_VALID & (vst_ff == V_IDLE);
	wire div_start = take_sample & en_q & ~dead;
	wire zero_now = take_sample & (~en_q | dead);
	wire [31:0] q32 = div_quo[31:0];

	sdmc_div u_div (
		.clk(CLOCK),
		.rst_n(RST_N),
		.start(div_start),
		.dividend(dividend),
		.divisor(divisor),
		.done(div_done),
		.quo(div_quo)
	);

	// test speed keeps its coded direction
	wire [31:0] test_vel = dec.ccw ? (32'h00000000 - RPM_TEST) : RPM_TEST;

	// target velocity; a dropped enable stops the motor at once rather
	// than waiting for the next sample
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			vst_ff <= V_IDLE;
			neg_ff <= 1'b0;
			target_ff <= 32'h00000000;
		end
		else
		begin
			unique case (vst_ff)
				V_IDLE:
				begin
					if (div_start)
					begin
						vst_ff <= V_DIV;
						neg_ff <= neg_nxt;
					end
				end
				V_DIV:
				begin
					if (div_done || !analog)
						vst_ff <= V_IDLE;
				end
			endcase
			if (op == OP_TEST)
				target_ff <= en_q ? test_vel : 32'h00000000;
			else if (!analog || !en_q || zero_now)
				target_ff <= 32'h00000000;
			else if (vst_ff == V_DIV && div_done)
				target_ff <= neg_ff ? (32'h00000000 - q32) : q32;
		end
	end

	// mode outputs
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			op_ff <= OP_FIELDBUS;
			closed_ff <= 1'b0;
			men_ff <= 1'b0;
		end
		else
		begin
			op_ff <= op;
			closed_ff <= special & dec.closed;
			men_ff <= special & en_q;
		end
	end

	assign HRDATA = rdata_ff;
	assign HREADYOUT = ready_ff;
	assign HRESP = 1'b0;
	assign STEP = step_ff;
	assign STEP_DIR = step_dir_ff;
	assign CLOSED_LOOP = closed_ff;
	assign OP_MODE = op_ff;
	assign MOTION_EN = men_ff;
	assign TARGET_VEL = target_ff;

	// configuration and mode checks
	AST_NOT_SPECIAL: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(active_ff.app_cat != ACT_SPECIAL) |=> (OP_MODE == OP_FIELDBUS))
		else $error("special mode active without activation value");
	AST_LOOP_BIT: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		special |=> (CLOSED_LOOP == $past(active_ff.mode[3])))
		else $error("closed loop output does not follow bit 3");
	AST_SAVE_SIG: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(wr_store && !sig_ok) |=> (saved_ff == $past(saved_ff)))
		else $error("configuration saved without signature");
	AST_RESTART: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		wr_restart |=> (active_ff == $past(saved_ff)))
		else $error("restart did not load saved configuration");
	AST_LIVE_HELD: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		!wr_restart |=> $stable(active_ff))
		else $error("live mode changed without a restart");
	AST_DIFF_EN: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		diff_ff |-> (en_q == (DIN[1] & ~DIN[0])))
		else $error("differential enable mapping wrong");

	// step checks
	AST_STEP_GATED: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(!en_q || op != OP_CLKDIR) |=> !STEP)
		else $error("step issued while disabled or not stepping");
	AST_STEP_DIR: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		step_nxt |=> (STEP && STEP_DIR == $past(dir_q)))
		else $error("step missing or wrong direction");
	AST_STEP_PULSE: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		STEP |=> !STEP)
		else $error("one clock edge gave more than one step");

	// speed checks; a restart may legally cut a conversion short
	AST_TEST_SPEED: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(op == OP_TEST && en_q && !dec.ccw) |=> (TARGET_VEL == 32'd30))
		else $error("test run speed wrong");
	AST_TEST_CCW: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(op == OP_TEST && en_q && dec.ccw) |=> (TARGET_VEL == 32'hffffffe2))
		else $error("counterclockwise test run speed wrong");
	AST_STILL_OFF: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(!en_q || (op != OP_TEST && !analog)) |=> (TARGET_VEL == 32'h00000000))
		else $error("speed target while disabled or not moving");
	AST_MOTION_EN: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		1'b1 |=> (MOTION_EN == $past(special && en_q)))
		else $error("motion enable does not follow input 1");
	AST_DEAD_ZONE: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(zero_now && !wr_restart) |=> (TARGET_VEL == 32'h00000000)[*2])
		else $error("motion inside dead zone");
	AST_ANALOG_DONE: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(div_start && !wr_restart) |=> (vst_ff == V_DIV) ##[47:48] div_done)
		else $error("analog speed not converted in time");
	AST_JOY_SIGN: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(div_start && dec.joystick) |=> (neg_ff == $past(ADC_DATA < ADC_HALF)))
		else $error("joystick sense wrong");
	AST_DIR_SIGN: assert property (
		@(posedge CLOCK) disable iff (!RST_N)
		(div_start && !dec.joystick) |=> (neg_ff != $past(dir_q)))
		else $error("analog sense does not follow direction input");
endmodule: sdmc_top

// *** hdl/sdmc_pkg.sv ***
// package: constants, types and mode decoding for the special drive modes
package sdmc_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_APP_CAT = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_STORE = 8'h08;
	localparam logic [7:0] OFS_RESTART = 8'h0c;
	localparam logic [7:0] OFS_SCALE_NUM = 8'h10;
	localparam logic [7:0] OFS_SCALE_DEN = 8'h14;
	localparam logic [7:0] OFS_DIFF = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	localparam logic [7:0] OFS_TARGET = 8'h20;

	// values after reset and key values
	localparam logic [7:0] RST_APP_CAT = 8'h00;
	localparam logic [3:0] RST_MODE = 4'h0;
	localparam logic [15:0] RST_SCALE = 16'h0001;
	localparam logic [7:0] ACT_SPECIAL = 8'h02;
	localparam logic [31:0] SAVE_SIG = 32'h65766173;

	// speeds in rpm
	localparam logic [9:0] RPM_FAST = 10'd1000;
	localparam logic [9:0] RPM_SLOW = 10'd100;
	localparam logic [31:0] RPM_TEST = 32'd30;

	// analog input: 12-bit converter, 10 V full scale, 20 mV dead band
	localparam int ADC_FULL_MV = 10000;
	localparam int DEAD_MV = 20;
	localparam logic [11:0] ADC_FULL = 12'hfff;
	localparam logic [11:0] ADC_HALF = 12'h800;
	localparam logic [11:0] DEAD_CNT = 12'(DEAD_MV * 4095 / ADC_FULL_MV);
	localparam logic [6:0] DIV_CYCLES = 7'd48;

	typedef enum logic [1:0] {OP_FIELDBUS, OP_CLKDIR, OP_VELOCITY, OP_TEST}
		sdmc_op_e;

	// stored configuration
	typedef struct packed {
		logic [7:0] app_cat;
		logic [3:0] mode;
	} sdmc_cfg_s;

	// decoded mode code
	typedef struct packed {
		sdmc_op_e op;
		logic closed;
		logic joystick;
		logic slow;
		logic ccw;
	} sdmc_dec_s;

	// mode code decode, used for the live mode and the staged status view
	function automatic sdmc_dec_s sdmc_decode(input logic [3:0] code);
		sdmc_dec_s d;
		d.closed = code[3];
		d.joystick = code[2] & code[1];
		d.slow = code[0];
		d.ccw = code[0];
		unique case (code[2:1])
			2'b00: d.op = OP_CLKDIR;
			2'b01: d.op = OP_TEST;
			2'b10: d.op = OP_VELOCITY;
			2'b11: d.op = OP_VELOCITY;
		endcase
		return d;
	endfunction: sdmc_decode

endpackage: sdmc_pkg

// *** hdl/sdmc_in_map.sv ***
// input pin mapper: single-ended or differential enable, direction, clock
`timescale 1ns/1ps
module sdmc_in_map
	import sdmc_pkg::*;
(
	// pins 2..7 as din[0]..din[5]
	input wire logic [5:0] din,
	input wire logic diff,
	// mapped levels
	output logic en,
	output logic dir,
	output logic clk
);
	// differential pairs read high when plus is high and minus is low
	wire en_d = din[1] & ~din[0];
	wire dir_d = din[3] & ~din[2];
	wire clk_d = din[5] & ~din[4];

	// pick the grouping
	assign en = diff ? en_d : din[0];
	assign dir = diff ? dir_d : din[1];
	assign clk = diff ? clk_d : din[2];
endmodule: sdmc_in_map

// *** hdl/sdmc_div.sv ***
// serial restoring divider for the scaled speed
`timescale 1ns/1ps
module sdmc_div
	import sdmc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// request
	input wire logic start,
	input wire logic [47:0] dividend,
	input wire logic [31:0] divisor,
	// answer
	output logic done,
	output logic [47:0] quo
);
	logic [32:0] rem_ff;
	logic [47:0] quo_ff;
	logic [31:0] dsr_ff;
	logic [6:0] cnt_ff;
	logic done_ff;

	// one quotient bit per cycle keeps the area small
	wire [32:0] rem_sh = {rem_ff[31:0], quo_ff[47]};
	wire [33:0] trial = {1'b0, rem_sh} - {2'b00, dsr_ff};
	wire take = ~trial[33];

	// divider state
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rem_ff <= '0;
			quo_ff <= '0;
			dsr_ff <= '0;
			cnt_ff <= '0;
			done_ff <= 1'b0;
		end
		else if (start)
		begin
			rem_ff <= '0;
			quo_ff <= dividend;
			dsr_ff <= divisor;
			cnt_ff <= DIV_CYCLES;
			done_ff <= 1'b0;
		end
		else if (cnt_ff != 7'd0)
		begin
			rem_ff <= take ? trial[32:0] : rem_sh;
			quo_ff <= {quo_ff[46:0], take};
			cnt_ff <= cnt_ff - 7'd1;
			done_ff <= (cnt_ff == 7'd1);
		end
		else
			done_ff <= 1'b0;
	end

	assign done = done_ff;
	assign quo = quo_ff;

	AST_DIV_LATENCY: assert property (@(posedge clk) disable iff (!rst_n)
		start |-> ##49 done) else $error("divider latency wrong");
endmodule: sdmc_div

// *** verification/sdmc_src.sv ***
// outside command source: enable, direction, clock pins and analog samples
`timescale 1ns/1ps
module sdmc_src
	import sdmc_pkg::*;
(
	// clock
	input wire logic clk,
	// pins and analog sample
	output logic [5:0] din,
	output logic [11:0] adc_data,
	output logic adc_valid
);
	logic en, dir, ck, diff;

	// pin levels; the clock stands low outside pulse trains
	assign din = diff ? {ck, ~ck, dir, ~dir, en, ~en}
		: {3'h0, ck, dir, en};

	// quiet lines at time zero
	initial
	begin
		{en, dir, ck, diff, adc_valid} = 5'h0;
		adc_data = 12'h0;
	end

	// enable, direction and wiring kind, changed just after an edge
	task automatic lines(input logic e, input logic d, input logic df);
		@(posedge clk);
		en <= e;
		dir <= d;
		diff <= df;
	endtask: lines

	// clock pulses, each high one cycle and low at least two
	task automatic pulses(input int n);
		repeat (n)
		begin
			@(posedge clk);
			ck <= 1'b1;
			@(posedge clk);
			ck <= 1'b0;
			@(posedge clk);
		end
	endtask: pulses

	// one sample; afterwards the data lines show the inverse, not the value
	task automatic sample(input logic [11:0] v);
		@(posedge clk);
		adc_data <= v;
		adc_valid <= 1'b1;
		@(posedge clk);
		adc_valid <= 1'b0;
		adc_data <= ~v;
	endtask: sample
endmodule: sdmc_src

// *** verification/sdmc_top_bench.sv ***
// self-checking bench for the special drive mode controller
`timescale 1ns/1ps
module sdmc_top_bench;
	import sdmc_pkg::*;
	logic clk, rst_n, hsel, hwrite, hreadyout, hresp, step, step_dir;
	logic closed, mot_en, adc_v;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, tvel, seed, rv;
	logic [5:0] din;
	logic [11:0] adc, a;
	logic [15:0] num, den;
	logic [3:0] code;
	sdmc_op_e op;
	int n_mismatch, comparisons, n_step;
	logic [7:0] ofs[6] = '{OFS_APP_CAT, OFS_MODE, OFS_SCALE_NUM,
		OFS_SCALE_DEN, OFS_DIFF, 8'h24};
	logic [31:0] rst_v[6] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h0, 32'h0};
	logic [11:0] corner[8] = '{12'h000, 12'h008, 12'h009, 12'hfff,
		12'h7f8, 12'h7f7, 12'h808, 12'h809};

	// 50 MHz clock
	initial clk = 1'b0;
	always #10 clk = ~clk;

	// design and command source; hready is the one slave's hreadyout
	sdmc_top i_sdmc_top (.CLOCK(clk), .RST_N(rst_n), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
		.HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .DIN(din), .ADC_DATA(adc),
		.ADC_VALID(adc_v), .STEP(step), .STEP_DIR(step_dir),
		.CLOSED_LOOP(closed), .OP_MODE(op), .MOTION_EN(mot_en),
		.TARGET_VEL(tvel));
	sdmc_src i_sdmc_src (.clk(clk), .din(din), .adc_data(adc),
		.adc_valid(adc_v));

	// step pulses stand one cycle, so each high sample is one step
	always @(posedge clk)
		if (step === 1'b1) n_step <= n_step + 1;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction: xs

	// expected operating mode of a code
	function automatic sdmc_op_e exp_op(input logic [3:0] c);
		case (c[2:0])
			3'h0, 3'h1: return OP_CLKDIR;
			3'h2, 3'h3: return OP_TEST;
			default: return OP_VELOCITY;
		endcase
	endfunction: exp_op

	// expected analog speed; truncation matches a plain integer divide
	function automatic logic [31:0] exp_vel(input logic [3:0] c,
		input logic [11:0] v, input logic d);
		longint mag, span, mx, r;
		logic neg;
		mx = c[0] ? 100 : 1000;
		neg = c[1] ? v < 12'h800 : ~d;
		mag = c[1] ? (neg ? 2048 - v : v - 2048) : v;
		span = c[1] ? 2048 : 4095;
		if (mag <= DEAD_CNT) return 32'h0;
		r = mag * mx * num / (span * (den == 0 ? 1 : den));
		return neg ? 32'(-r) : 32'(r);
	endfunction: exp_vel

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t %s: got %h want %h", $time, m, got, exp);
		end
	endtask: chk

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask: give_verdict

	// wait for hready high at an edge, bounded
	task automatic wait_rdy();
		int k;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (hreadyout !== 1'b1 && k < 50);
		if (hreadyout !== 1'b1)
		begin
			chk(32'h0, 32'h1, "bus wait ran out");
			give_verdict();
		end
	endtask: wait_rdy

	// one single word transfer: address phase, then data phase
	task automatic ahb(input logic w, input logic [7:0] ad,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, ad};
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		r = hrdata;
	endtask: ahb

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, ad, d, r);
	endtask: wr

	// stage, save, restart
	task automatic cfg(input logic [7:0] cat, input logic [3:0] c);
		wr(OFS_APP_CAT, {24'h0, cat});
		wr(OFS_MODE, {28'h0, c});
		wr(OFS_STORE, SAVE_SIG);
		wr(OFS_RESTART, 32'h0);
		repeat (4) @(posedge clk);
	endtask: cfg

	initial
	begin
		seed = 32'd11;
		{rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{n_mismatch, comparisons, n_step} = '0;
		num = 16'h1;
		den = 16'h1;
		repeat (10) @(posedge clk);
		chk(32'({hreadyout, hresp, step, op, mot_en}), 32'h20, "in reset");
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			ahb(1'b0, ofs[i], 32'h0, rv);
			chk(rv, rst_v[i], "register after reset");
		end
		$display("test reset done");
		// staged mode must not act before save and restart
		i_sdmc_src.lines(1'b1, 1'b0, 1'b0);
		wr(OFS_APP_CAT, 32'h2);
		wr(OFS_MODE, 32'h3);
		wr(OFS_RESTART, 32'h0);
		wr(OFS_STORE, ~SAVE_SIG);
		wr(OFS_RESTART, 32'h0);
		wr(OFS_STORE, SAVE_SIG);
		repeat (4) @(posedge clk);
		chk(32'(op), 32'(OP_FIELDBUS), "acted before restart");
		wr(OFS_RESTART, 32'h0);
		repeat (4) @(posedge clk);
		chk(32'(op), 32'(OP_TEST), "restart after save");
		chk(tvel, -32'd30, "test ccw");
		$display("test commit done");
		for (int c = 0; c < 16; c++)
		begin
			cfg(8'h2, 4'(c));
			chk(32'(op), 32'(exp_op(4'(c))), "op");
			chk(32'(closed), 32'(c[3]), "loop");
			chk(32'(mot_en), 32'h1, "enable");
			if (exp_op(4'(c)) == OP_TEST)
				chk(tvel, c[0] ? -32'd30 : 32'd30, "test speed");
			ahb(1'b0, OFS_STATUS, 32'h0, rv);
			chk(rv & 32'h200f, 32'h2000 | 32'(c), "status");
		end
		cfg(8'h1, 4'h2);
		chk(32'({op, closed, mot_en}), 32'h0, "not special");
		chk(tvel, 32'h0, "not special speed");
		cfg(8'h2, 4'ha);
		i_sdmc_src.lines(1'b0, 1'b0, 1'b0);
		repeat (3) @(posedge clk);
		chk(tvel, 32'h0, "test disabled");
		chk(32'(mot_en), 32'h0, "enable low");
		$display("test codes done");
		// steps with random enable, direction, wiring and count
		cfg(8'h2, 4'h9);
		for (int i = 0; i < 8; i++)
		begin
			rv = xs();
			i_sdmc_src.lines(rv[0], rv[1], rv[2]);
			wr(OFS_DIFF, {31'h0, rv[2]});
			repeat (3) @(posedge clk);
			n_step = 0;
			i_sdmc_src.pulses(rv[5:3] + 1);
			repeat (3) @(posedge clk);
			chk(32'(n_step), rv[0] ? rv[5:3] + 1 : 0, "steps");
			if (rv[0])
				chk(32'(step_dir), 32'(rv[1]), "dir");
		end
		wr(OFS_DIFF, 32'h0);
		cfg(8'h2, 4'h4);
		i_sdmc_src.lines(1'b1, 1'b1, 1'b0);
		n_step = 0;
		i_sdmc_src.pulses(3);
		repeat (3) @(posedge clk);
		chk(32'(n_step), 32'h0, "step outside stepping");
		$display("test steps done");
		// analog speed: corners first, then random samples and scaling
		for (int i = 0; i < 24; i++)
		begin
			rv = xs();
			code = {rv[2], 1'b1, i < 4 ? 1'b0 : (i < 8 ? 1'b1 : rv[1]), rv[0]};
			a = i < 8 ? corner[i] : rv[19:8];
			num = i < 12 ? 16'h1 : 16'(rv[23:20]);
			den = i < 12 ? 16'h1 : 16'(rv[27:24]);
			wr(OFS_SCALE_NUM, 32'(num));
			wr(OFS_SCALE_DEN, 32'(den));
			cfg(8'h2, code);
			i_sdmc_src.lines(1'b1, rv[3], 1'b0);
			i_sdmc_src.sample(a);
			repeat (55) @(posedge clk);
			chk(tvel, exp_vel(code, a, rv[3]), "speed");
		end
		i_sdmc_src.lines(1'b0, 1'b1, 1'b0);
		repeat (3) @(posedge clk);
		chk(tvel, 32'h0, "analog disabled");
		$display("test analog done");
		give_verdict();
	end
endmodule: sdmc_top_bench
